// ==== core/dpr_cmd.sv ====
// power-down, update-all and reference command decoder
`timescale 1ns/1ps
`default_nettype none
module dpr_cmd (
    // system
    input wire logic clk,
    input wire logic rstn,
    // serial link
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic din,
    // channel outputs
    output logic [dpr_pkg::CHANNELS*dpr_pkg::CODE_W-1:0] chan_code,
    output logic chan_update,
    output logic [2*dpr_pkg::CHANNELS-1:0] chan_pd_mode,
    // reference control
    output logic ref_flexible,
    output logic ref_always_on,
    output logic ref_out_oe
);
    dpr_frame_if frame_bus ();

    dpr_frame_rx u_rx (
        .sclk(sclk),
        .rstn(rstn),
        .sync_n(sync_n),
        .din(din),
        .link(frame_bus.rx)
    );

    ////////////////////////////////////////////////////////////////////////
    // toggle crossing into clk domain
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_seen;
    logic frame_ok;
    logic [dpr_pkg::FRAME_W-1:0] word;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tgl_meta <= 1'b0;
            tgl_sync <= 1'b0;
            tgl_seen <= 1'b0;
        end
        else
        begin
            tgl_meta <= frame_bus.tgl;
            tgl_sync <= tgl_meta;
            tgl_seen <= tgl_sync;
        end
    end

    // word is quiet for a whole frame after the toggle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            word <= '0;
            frame_ok <= 1'b0;
        end
        else
        begin
            frame_ok <= tgl_sync ^ tgl_seen;
            if (tgl_sync ^ tgl_seen)
                word <= frame_bus.word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decode
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [dpr_pkg::CODE_W-1:0] wdata;
    logic [2:0] refsel;
    logic [1:0] pd_mode;
    logic [dpr_pkg::CHANNELS-1:0] mask;
    logic [2*dpr_pkg::CHANNELS-1:0] mask2;
    logic frame_valid;
    logic is_pd;
    logic is_all_wr;
    logic is_static;
    logic is_flex;

    assign cmd = word[dpr_pkg::CMD_HI:dpr_pkg::CMD_LO];
    assign addr = word[dpr_pkg::ADDR_HI:dpr_pkg::ADDR_LO];
    assign wdata = word[dpr_pkg::DATA_HI:dpr_pkg::DATA_LO];
    assign refsel = word[dpr_pkg::REFSEL_HI:dpr_pkg::REFSEL_LO];
    assign pd_mode = word[dpr_pkg::PD_MODE_HI:dpr_pkg::PD_MODE_LO];
    assign mask = word[dpr_pkg::MASK_HI:dpr_pkg::MASK_LO];
    // prefix bit set marks a malformed frame
    assign frame_valid = frame_ok && !word[dpr_pkg::PREFIX_BIT];
    // address bits play no part in power-down
    assign is_pd = frame_valid && cmd == dpr_pkg::CMD_PWR_DOWN;
    assign is_all_wr = frame_valid && addr == dpr_pkg::ADDR_ALL
        && (cmd == dpr_pkg::CMD_WR_UPD_ALL
        || cmd == dpr_pkg::CMD_WR_UPD_CH);
    assign is_static = frame_valid && cmd == dpr_pkg::CMD_REF_STATIC;
    assign is_flex = frame_valid && cmd == dpr_pkg::CMD_REF_FLEX;

    ////////////////////////////////////////////////////////////////////////
    // per-channel mode and code
    logic [2*dpr_pkg::CHANNELS-1:0] next_pd_mode;
    logic [dpr_pkg::CHANNELS-1:0] chan_up;

    genvar gi;
    generate
        for (gi = 0; gi < dpr_pkg::CHANNELS; gi++)
        begin : g_chan
            assign mask2[2*gi+1:2*gi] = {2{mask[gi]}};
            assign next_pd_mode[2*gi+1:2*gi] = (is_pd && mask[gi])
                ? pd_mode : chan_pd_mode[2*gi+1:2*gi];
            assign chan_up[gi] =
                next_pd_mode[2*gi+1:2*gi] == dpr_pkg::PD_NORMAL;

            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    chan_pd_mode[2*gi+1:2*gi] <= dpr_pkg::PD_NORMAL;
                else
                    chan_pd_mode[2*gi+1:2*gi] <=
                        next_pd_mode[2*gi+1:2*gi];
            end

            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    chan_code[dpr_pkg::CODE_W*gi +: dpr_pkg::CODE_W] <=
                        dpr_pkg::RST_CODE;
                else if (is_all_wr)
                    chan_code[dpr_pkg::CODE_W*gi +: dpr_pkg::CODE_W] <=
                        wdata;
            end
        end
    endgenerate

    // all channels move on one common strobe
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            chan_update <= 1'b0;
        else
            chan_update <= is_all_wr;
    end

    ////////////////////////////////////////////////////////////////////////
    // reference mode
    dpr_pkg::dpr_ref_mode_e ref_mode;
    dpr_pkg::dpr_ref_mode_e next_ref_mode;
    logic ref_req;
    logic next_ref_req;
    logic next_ref_on;

    always_comb
    begin
        next_ref_mode = ref_mode;
        next_ref_req = ref_req;
        if (is_static && ref_mode == dpr_pkg::REF_STATIC)
            next_ref_req = word[dpr_pkg::FEAT0_BIT];
        if (is_flex)
        begin
            case (refsel)
                dpr_pkg::REFSEL_AUTO:
                begin
                    next_ref_mode = dpr_pkg::REF_FLEX_AUTO;
                    next_ref_req = 1'b1;
                end
                dpr_pkg::REFSEL_ON:
                    next_ref_mode = dpr_pkg::REF_FLEX_ON;
                dpr_pkg::REFSEL_OFF:
                    next_ref_mode = dpr_pkg::REF_FLEX_OFF;
                dpr_pkg::REFSEL_BACK:
                begin
                    next_ref_mode = dpr_pkg::REF_STATIC;
                    next_ref_req = 1'b0;
                end
                default:
                    next_ref_mode = ref_mode;
            endcase
        end
    end

    // automatic modes follow the channels; forced modes ignore them
    always_comb
    begin
        case (next_ref_mode)
            dpr_pkg::REF_STATIC:
                next_ref_on = next_ref_req && (|chan_up);
            dpr_pkg::REF_FLEX_AUTO:
                next_ref_on = next_ref_req && (|chan_up);
            dpr_pkg::REF_FLEX_ON:
                next_ref_on = 1'b1;
            dpr_pkg::REF_FLEX_OFF:
                next_ref_on = 1'b0;
            default:
                next_ref_on = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ref_mode <= dpr_pkg::REF_STATIC;
            ref_req <= dpr_pkg::RST_REF_REQ;
        end
        else
        begin
            ref_mode <= next_ref_mode;
            ref_req <= next_ref_req;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ref_out_oe <= 1'b0;
            ref_flexible <= 1'b0;
            ref_always_on <= 1'b0;
        end
        else
        begin
            ref_out_oe <= next_ref_on;
            ref_flexible <= next_ref_mode != dpr_pkg::REF_STATIC;
            ref_always_on <= next_ref_mode == dpr_pkg::REF_FLEX_ON;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic seen_ref;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            seen_ref <= 1'b0;
        else if (is_static || is_flex)
            seen_ref <= 1'b1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_pd_sel;
        is_pd |=> ((chan_pd_mode ^ {8{$past(pd_mode)}})
            & $past(mask2)) == 16'h0000;
    endproperty
    a_pd_sel: assert property (p_pd_sel)
        else $error("selected channel missed its power-down mode");

    property p_pd_keep;
        is_pd |=> ((chan_pd_mode ^ $past(chan_pd_mode))
            & ~$past(mask2)) == 16'h0000;
    endproperty
    a_pd_keep: assert property (p_pd_keep)
        else $error("unselected channel changed mode");

    property p_pd_quiet;
        !is_pd |=> $stable(chan_pd_mode);
    endproperty
    a_pd_quiet: assert property (p_pd_quiet)
        else $error("channel mode changed without a power-down frame");

    property p_hiz_all;
        is_pd && pd_mode == 2'h3 && mask == 8'hFF
            |=> chan_pd_mode == 16'hFFFF;
    endproperty
    a_hiz_all: assert property (p_hiz_all)
        else $error("all-channel high impedance not applied");

    property p_all_wr;
        is_all_wr |=> chan_update && chan_code == {8{$past(wdata)}};
    endproperty
    a_all_wr: assert property (p_all_wr)
        else $error("update-all did not load every channel");

    property p_upd_cause;
        chan_update |-> $past(frame_ok) && !$past(word[31]);
    endproperty
    a_upd_cause: assert property (p_upd_cause)
        else $error("update without a complete frame");

    property p_flex_on;
        is_flex && refsel == 3'h5 |=> ref_always_on && ref_out_oe
            && ref_flexible;
    endproperty
    a_flex_on: assert property (p_flex_on)
        else $error("reference not forced on");

    property p_flex_off;
        is_flex && refsel == 3'h6 |=> !ref_out_oe [*2];
    endproperty
    a_flex_off: assert property (p_flex_off)
        else $error("reference not forced off");

    property p_always_pd;
        ref_always_on && is_pd && !is_flex |=> ref_out_oe;
    endproperty
    a_always_pd: assert property (p_always_pd)
        else $error("power-down disturbed an always-on reference");

    property p_static_en;
        is_static && !ref_flexible |=> ref_req == $past(word[0])
            && !ref_flexible;
    endproperty
    a_static_en: assert property (p_static_en)
        else $error("static reference frame not applied");

    property p_static_lock;
        is_static && ref_flexible |=> $stable(ref_req)
            && $stable(ref_mode);
    endproperty
    a_static_lock: assert property (p_static_lock)
        else $error("static frame acted in flexible mode");

    property p_boot_off;
        !seen_ref |-> !ref_out_oe && !ref_flexible;
    endproperty
    a_boot_off: assert property (p_boot_off)
        else $error("reference on before any reference frame");

    c_hiz: cover property (is_pd && pd_mode == 2'h3 && mask == 8'hFF);
    c_flex_on_pd: cover property (ref_always_on && is_pd);
    c_all_wr: cover property (is_all_wr ##[1:200] is_all_wr);
    c_back: cover property (ref_flexible ##1 !ref_flexible);
endmodule // dpr_cmd
`default_nettype wire

// ==== core/dpr_pkg.sv ====
// constants and types of the power-down / reference command decoder
//
// Notes on behaviour
// - A power-down frame selects channels with a mask in bits 7..0, bit 0 for channel A up to bit 7 for channel H.
// - Bits 9..8 of a power-down frame give the mode: 01 is the 1 kilohm pull-down, 10 the 100 kilohm pull-down.
// - Mode 11 with all eight mask bits set puts every output in high impedance, whatever the address bits hold.
// - Each selected channel takes its new mode when the frame completes and unselected channels keep theirs.
// - A write-and-update frame with address 1111 loads its data into all channels and updates all eight together.
// - A flexible reference frame (code 1001) with bits 19..17 at 101 keeps the internal reference always on.
// - A flexible reference frame with bits 19..17 at 110 keeps the internal reference always off.
// - After power-up the internal reference is off until a reference frame turns it on.
// - While the internal reference is off its output buffer does not drive the shared reference pin.
// - There are exactly two reference control modes, static and flexible, chosen by the reference frames.
// - With the reference always on, power-down frames leave the reference state untouched.
// - In static mode a code 1000 frame turns the reference on when feature bit 0 is one and any channel is powered up, and off when it is zero.
// - In flexible mode static frames do nothing until the switch-back frame restores static mode.
////////////////////////////////////////////////////////////////////////////////
`default_nettype none
package dpr_pkg;
    // frame layout
    localparam int FRAME_W = 32;
    localparam int CNT_W = 6;
    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam logic [5:0] LAST_BIT = 6'h1F;
    localparam int PREFIX_BIT = 31;
    localparam int CMD_HI = 27;
    localparam int CMD_LO = 24;
    localparam int ADDR_HI = 23;
    localparam int ADDR_LO = 20;
    localparam int DATA_HI = 19;
    localparam int DATA_LO = 4;
    localparam int REFSEL_HI = 19;
    localparam int REFSEL_LO = 17;
    localparam int PD_MODE_HI = 9;
    localparam int PD_MODE_LO = 8;
    localparam int MASK_HI = 7;
    localparam int MASK_LO = 0;
    localparam int FEAT0_BIT = 0;
    // channels
    localparam int CHANNELS = 8;
    localparam int CODE_W = 16;
    // command codes
    localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
    localparam logic [3:0] CMD_WR_UPD_CH = 4'h3;
    localparam logic [3:0] CMD_PWR_DOWN = 4'h4;
    localparam logic [3:0] CMD_REF_STATIC = 4'h8;
    localparam logic [3:0] CMD_REF_FLEX = 4'h9;
    localparam logic [3:0] ADDR_ALL = 4'hF;
    // flexible reference selections
    localparam logic [2:0] REFSEL_AUTO = 3'h4;
    localparam logic [2:0] REFSEL_ON = 3'h5;
    localparam logic [2:0] REFSEL_OFF = 3'h6;
    localparam logic [2:0] REFSEL_BACK = 3'h0;
    // channel output modes
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_1K = 2'h1;
    localparam logic [1:0] PD_100K = 2'h2;
    localparam logic [1:0] PD_HIZ = 2'h3;
    // reset values
    localparam logic RST_REF_REQ = 1'h0;
    localparam logic [15:0] RST_CODE = 16'h0000;

    typedef enum logic [1:0] {
        REF_STATIC = 2'b00,
        REF_FLEX_AUTO = 2'b01,
        REF_FLEX_ON = 2'b10,
        REF_FLEX_OFF = 2'b11
    } dpr_ref_mode_e;
endpackage
`default_nettype wire

// ==== core/dpr_frame_if.sv ====
// frame hand-off between serial receiver and command decoder
`timescale 1ns/1ps
`default_nettype none
interface dpr_frame_if;
    logic [31:0] word;
    logic tgl;
    modport rx (output word, output tgl);
    modport cmd (input word, input tgl);
endinterface
`default_nettype wire

// ==== core/dpr_frame_rx.sv ====
// serial frame receiver on the link clock
`timescale 1ns/1ps
`default_nettype none
module dpr_frame_rx (
    // serial link
    input wire logic sclk,
    input wire logic rstn,
    input wire logic sync_n,
    input wire logic din,
    // frame hand-off
    dpr_frame_if.rx link
);
    logic [dpr_pkg::CNT_W-1:0] bit_cnt;
    logic [dpr_pkg::FRAME_W-1:0] shift;
    logic [dpr_pkg::FRAME_W-1:0] word;
    logic tgl;

    ////////////////////////////////////////////////////////////////////////
    // bit counter, cleared whenever the frame sync is high
    always_ff @(negedge sclk or negedge rstn or posedge sync_n)
    begin
        if (!rstn)
            bit_cnt <= '0;
        else if (sync_n)
            bit_cnt <= '0;
        else if (bit_cnt != dpr_pkg::FRAME_BITS)
            bit_cnt <= bit_cnt + 6'h01;
    end

    // msb first shift
    always_ff @(negedge sclk or negedge rstn)
    begin
        if (!rstn)
            shift <= '0;
        else if (!sync_n && bit_cnt != dpr_pkg::FRAME_BITS)
            shift <= {shift[30:0], din};
    end

    // whole word on the 32nd falling edge, announced by a toggle
    always_ff @(negedge sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            word <= '0;
            tgl <= 1'b0;
        end
        else if (!sync_n && bit_cnt == dpr_pkg::LAST_BIT)
        begin
            word <= {shift[30:0], din};
            tgl <= ~tgl;
        end
    end

    assign link.word = word;
    assign link.tgl = tgl;
endmodule // dpr_frame_rx
`default_nettype wire

// ==== verification/dpr_host_model.sv ====
// host controller model driving the serial write link
`timescale 1ns/1ps
`default_nettype none
module dpr_host_model (
    // serial link
    output logic sclk,
    output logic sync_n,
    output logic din
);
    initial
    begin
        sclk = 1'h1;
        sync_n = 1'h1;
        din = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame; 64 ns link clock runs only inside the frame
    task automatic send(input logic [31:0] word, input int nbits);
        int i;
        #7;
        sync_n = 1'h0;
        for (i = 0; i < nbits; i++)
        begin
            din = word[31 - i]; // msb first
            #16 sclk = 1'h0;
            #32 sclk = 1'h1;
            #16;
        end
        #16 sync_n = 1'h1; // frame closed only after all its bits
        din = ~din; // released line shows no stale level
    endtask
endmodule // dpr_host_model
`default_nettype wire

// ==== verification/dpr_cmd_tb.sv ====
// self-checking bench of the command decoder
`timescale 1ns/1ps
`default_nettype none
module dpr_cmd_tb;
    logic clk;
    logic rstn;
    wire logic sclk;
    wire logic sync_n;
    wire logic din;
    logic [127:0] chan_code;
    logic chan_update;
    logic [15:0] chan_pd_mode;
    logic ref_flexible;
    logic ref_always_on;
    logic ref_out_oe;
    int failures;
    int compares;
    int cycles;
    int upd_cnt;
    int seed;
    int n;
    logic [1:0] m_pd [8];
    logic [15:0] m_code;
    logic m_req;
    int m_upd;
    dpr_pkg::dpr_ref_mode_e m_mode;

    dpr_cmd dut (.clk(clk), .rstn(rstn), .sclk(sclk), .sync_n(sync_n),
        .din(din), .chan_code(chan_code), .chan_update(chan_update),
        .chan_pd_mode(chan_pd_mode), .ref_flexible(ref_flexible),
        .ref_always_on(ref_always_on), .ref_out_oe(ref_out_oe));
    dpr_host_model host (.sclk(sclk), .sync_n(sync_n), .din(din));

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // sampled away from the edge that launches the pulse
    always @(negedge clk)
    begin
        cycles++;
        if (chan_update === 1'h1)
            upd_cnt++;
        if (cycles == 30000)
        begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // expectation model
    task automatic model_reset();
        int i;
        for (i = 0; i < 8; i++)
            m_pd[i] = 2'h0;
        m_code = 16'h0000;
        m_req = 1'h0;
        m_mode = dpr_pkg::REF_STATIC;
    endtask

    task automatic apply(input logic [31:0] w);
        int i;
        m_upd = 0;
        if (w[31] !== 1'h0)
            return;
        case (w[27:24])
            4'h2, 4'h3:
                if (w[23:20] == 4'hF)
                begin
                    m_code = w[19:4];
                    m_upd = 1;
                end
            4'h4:
                for (i = 0; i < 8; i++)
                    if (w[i])
                        m_pd[i] = w[9:8];
            4'h8:
                if (m_mode == dpr_pkg::REF_STATIC)
                    m_req = w[0];
            4'h9:
                case (w[19:17])
                    3'h4:
                    begin
                        m_mode = dpr_pkg::REF_FLEX_AUTO;
                        m_req = 1'h1;
                    end
                    3'h5: m_mode = dpr_pkg::REF_FLEX_ON;
                    3'h6: m_mode = dpr_pkg::REF_FLEX_OFF;
                    3'h0:
                    begin
                        m_mode = dpr_pkg::REF_STATIC;
                        m_req = 1'h0;
                    end
                    default: ;
                endcase
            default: ;
        endcase
    endtask

    function automatic logic [15:0] pd_vec();
        int i;
        logic [15:0] v;
        for (i = 0; i < 8; i++)
            v[2*i +: 2] = m_pd[i];
        return v;
    endfunction

    function automatic logic exp_oe();
        int i;
        logic any_up;
        any_up = 1'h0;
        for (i = 0; i < 8; i++)
            any_up = any_up | (m_pd[i] == 2'h0);
        if (m_mode == dpr_pkg::REF_FLEX_ON)
            return 1'h1;
        if (m_mode == dpr_pkg::REF_FLEX_OFF)
            return 1'h0;
        return m_req & any_up;
    endfunction

    function automatic logic [31:0] rand_frame(input logic [31:0] r,
        input logic [31:0] s);
        logic [2:0] sel;
        case (s[4:3])
            2'h0: sel = 3'h4;
            2'h1: sel = 3'h5;
            2'h2: sel = 3'h6;
            default: sel = 3'h0;
        endcase
        case (s[2:0])
            3'h2: return {1'h0, r[30:28], 3'h1, s[5], 4'hF, r[19:0]};
            3'h3: return {1'h0, r[30:28], 4'h8, r[23:0]};
            3'h4: return {1'h0, r[30:28], 4'h9, r[23:20], sel, r[16:0]};
            3'h5: return {1'h0, r[30:28], 4'h0, r[23:0]};
            default: return {1'h0, r[30:28], 4'h4, r[23:10], s[9:8], s[7:0]};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // checks and frames
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic check_all();
        check(128'(chan_pd_mode), 128'(pd_vec()));
        check(chan_code, {8{m_code}});
        check(128'(ref_flexible),
            128'(m_mode != dpr_pkg::REF_STATIC));
        check(128'(ref_always_on),
            128'(m_mode == dpr_pkg::REF_FLEX_ON));
        check(128'(ref_out_oe), 128'(exp_oe()));
    endtask

    task automatic frame(input logic [31:0] w, input int nbits);
        upd_cnt = 0;
        host.send(w, nbits);
        if (nbits == 32)
            apply(w);
        else
            m_upd = 0;
        repeat (10) @(negedge clk);
        check_all();
        check(128'(upd_cnt), 128'(m_upd));
    endtask

    task automatic stop_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        seed = 30577;
        rstn = 1'h0;
        failures = 0;
        compares = 0;
        cycles = 0;
        upd_cnt = 0;
        model_reset();
        repeat (10) @(negedge clk);
        rstn = 1'h1;
        @(negedge clk);
        check_all();
        frame(32'h0400_0103, 32);
        frame(32'h0400_0180, 32);
        frame(32'h0400_020C, 32);
        frame(32'h0400_0220, 32);
        frame(32'h0800_0001, 32);
        frame(32'h04A5_43FF, 32);
        frame(32'h0400_00FF, 32);
        frame(32'h0800_0000, 32);
        frame(32'h090A_0000, 32);
        frame(32'h0430_03FF, 32);
        frame(32'h090C_0000, 32);
        frame(32'h0800_0001, 32);
        frame(32'h0900_0000, 32);
        frame(32'h090E_0000, 32);
        frame(32'h0400_00FF, 32);
        frame(32'h0800_0001, 32);
        frame(32'h03F0_1230, 32);
        frame(32'h02FA_BCD5, 32);
        frame(32'h0400_03FF, 31);
        frame(32'h8400_03FF, 32);
        for (n = 0; n < 50; n++)
            frame(rand_frame($random(seed), $random(seed)), 32);
        @(negedge clk);
        rstn = 1'h0;
        model_reset();
        repeat (3) @(negedge clk);
        check_all();
        rstn = 1'h1;
        frame(32'h0908_0000, 32);
        stop_test();
    end
endmodule // dpr_cmd_tb
`default_nettype wire
